// ==== core/wrap_pos_defs.svh ====
// register offsets, field positions, reset values and counts of the coordinate manager
`ifndef WRAP_POS_DEFS_SVH
`define WRAP_POS_DEFS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define WP_OFF_CTRL       8'h00
`define WP_OFF_RANGE      8'h04
`define WP_OFF_RATIO      8'h08
`define WP_OFF_OFSVAL     8'h0C
`define WP_OFF_HOME_OFS   8'h10
`define WP_OFF_CMD        8'h14
`define WP_OFF_STATUS     8'h18
`define WP_OFF_FB_CNT     8'h1C
`define WP_OFF_CMD_CNT    8'h20
`define WP_OFF_WRAP_POS   8'h24
`define WP_OFF_REVS       8'h28
`define WP_OFF_NVM_WRITES 8'h2C

// ----------------------------------------
// field positions
// ----------------------------------------
`define WP_CTRL_WRAP_EN   0
`define WP_CTRL_MANUAL    1
`define WP_CTRL_PERMIT    2
`define WP_CMD_PRESET     0
`define WP_CMD_CLEAR      1
`define WP_CMD_REINIT     2
`define WP_CMD_RESOL      3

// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define WP_RST_RANGE      32'h0000_0000
`define WP_RST_RATIO      14'h0000
`define WP_RST_OFSVAL     32'h0000_0000
`define WP_RST_HOME_OFS   32'h0000_0000
`define WP_RATIO_FULL     14'h2710
`define WP_DIV_STEPS      6'h20
`define WP_SPAN_REVS      1800
`define WP_STEPS_PER_REV  10000
`define WP_NVM_LIMIT      100000

`endif

// ==== core/wrap_pos_pkg.sv ====
// types of the wrap position coordinate manager
package wrap_pos_pkg;

  typedef enum logic [1:0] {
    ST_INIT,
    ST_DIV,
    ST_RUN
  } state_e;

  typedef struct packed {
    state_e      state;
    logic        wrap_en;
    logic        manual;
    logic        permit;
    logic [31:0] range;
    logic [13:0] ratio;
    logic [31:0] ofsval;
    logic [31:0] home_ofs;
    logic [31:0] act_len;
    logic [31:0] act_min;
    logic        act_wrap;
    logic [31:0] cmd_cnt;
    logic [31:0] fb_cnt;
    logic [31:0] wrap_pos;
    logic [31:0] sub_step;
    logic [15:0] revs;
    logic        user_home;
    logic        coord_set;
    logic        preset_nz;
    logic        neg;
    logic [5:0]  div_cnt;
    logic [32:0] rem;
    logic [31:0] dvd;
    logic [31:0] prdata;
    logic        nvm_we;
    logic [32:0] nvm_wdata;
  } state_s;

endpackage : wrap_pos_pkg

// ==== core/wrap_pos_home_store.sv ====
// non-volatile home record with rewrite counter and wear-out lock
`timescale 1ns/100ps
`include "wrap_pos_defs.svh"
module wrap_pos_home_store #(
  parameter int WRITE_LIMIT = `WP_NVM_LIMIT,
  parameter int CNT_W       = 17
) (
  input  wire logic             clk_i,     // system clock
  input  wire logic             rst_n_i,   // synchronised reset, active low
  input  wire logic             we_i,      // write strobe
  input  wire logic [32:0]      wdata_i,   // {valid, home offset}
  output logic      [32:0]      rdata_o,   // stored record
  output logic      [CNT_W-1:0] writes_o,  // writes done so far
  output logic                  worn_o     // write limit reached
);

  localparam logic [CNT_W-1:0] LIMIT = CNT_W'(WRITE_LIMIT);

  logic [32:0]      record;
  logic [CNT_W-1:0] writes;

  assign worn_o   = (writes >= LIMIT);
  assign writes_o = writes;

  // ----------------------------------------
  // record and counter
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      record  <= 33'h0_0000_0000;
      writes  <= '0;
      rdata_o <= 33'h0_0000_0000;
    end else begin
      // writes stop at the wear limit
      if (we_i && !worn_o) begin
        record <= wdata_i;
        writes <= writes + CNT_W'(1);
      end
      rdata_o <= record;
    end
  end

endmodule : wrap_pos_home_store

// ==== core/wrap_position_coordinate_manager.sv ====
// wrap position coordinate manager: step counters, wrap position, home flags, apb registers
//
// What this block does
// - wrap re-presets presented position into range
// - wrap never reloads the step counter
// - step counter counts with wrap on or off
// - step counter rolls over both directions
// - offset range flips sign at boundary
// - coordinate valid output when coordinate set
// - refuse homing without coordinate; absolute too unless permit is set
// - factory home flag, stored home locked
// - user home flag after homing or preset
// - home stored in nvm, writes limited
// - preset loads both counters with offset
// - home offset full signed, resets zero
// - coordinate unset in listed cases
// - preset clear releases user home
// - wrap settings apply after reinit, preset or homing completion
// - positioning referenced to home centre
// - coordinate regenerated at every power-up
// - revolution count wraps past span
`timescale 1ns/100ps
`include "wrap_pos_defs.svh"
module wrap_position_coordinate_manager #(
  parameter int STEPS_PER_REV = `WP_STEPS_PER_REV,
  parameter int SPAN_REVS     = `WP_SPAN_REVS,
  parameter int NVM_LIMIT     = `WP_NVM_LIMIT
) (
  input  wire logic        clk_i,             // 20 MHz clock
  input  wire logic        reset_n_i,         // async reset, active low
  input  wire logic        psel_i,            // apb select
  input  wire logic        penable_i,         // apb enable
  input  wire logic        pwrite_i,          // apb direction
  input  wire logic [7:0]  paddr_i,           // apb byte address
  input  wire logic [31:0] pwdata_i,          // apb write data
  output logic      [31:0] prdata_o,          // apb read data
  output logic             pready_o,          // apb ready
  output logic             pslverr_o,         // apb error
  input  wire logic        cmd_step_i,        // command step pulse
  input  wire logic        cmd_dir_i,         // command direction, 1 positive
  input  wire logic        fb_step_i,         // feedback step pulse
  input  wire logic        fb_dir_i,          // feedback direction, 1 positive
  input  wire logic        homing_i,          // homing in progress
  input  wire logic        homing_done_i,     // homing finished pulse
  input  wire logic        factory_home_i,    // sensor holds factory home
  input  wire logic        abs_pos_req_i,     // absolute positioning request
  input  wire logic        hs_home_req_i,     // high-speed homing request
  output logic             abs_pos_ok_o,      // absolute positioning granted
  output logic             hs_home_ok_o,      // high-speed homing granted
  output logic             coordinate_valid_flag_o, // coordinate established
  output logic             factory_home_flag_o,     // factory home present
  output logic             user_home_flag_o,        // user home present
  output logic [31:0]      command_step_counter_o,  // command step count
  output logic [31:0]      feedback_step_counter_o, // feedback step count
  output logic [31:0]      wrap_pos_o               // presented position
);

  localparam logic [31:0] SPR_LAST = 32'(STEPS_PER_REV - 1);
  localparam logic [15:0] SPAN     = 16'(SPAN_REVS);

  wrap_pos_pkg::state_s r;
  wrap_pos_pkg::state_s next_r;
  logic [1:0]           rst_sync;
  logic                 rst_n;
  logic [32:0]          nvm_rdata;
  logic [16:0]          nvm_writes;
  logic                 nvm_worn;

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_n = rst_sync[1];

  // ----------------------------------------
  // home record store
  // ----------------------------------------
  wrap_pos_home_store #(
    .WRITE_LIMIT (NVM_LIMIT),
    .CNT_W       (17)
  ) u_store (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n),
    .we_i     (r.nvm_we),
    .wdata_i  (r.nvm_wdata),
    .rdata_o  (nvm_rdata),
    .writes_o (nvm_writes),
    .worn_o   (nvm_worn)
  );

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= `WP_OFF_NVM_WRITES);
  endfunction : mapped

  // ----------------------------------------
  // apb handshake and flags
  // ----------------------------------------
  logic apb_wr;
  logic init_busy;
  logic busy_op;

  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped(paddr_i);
  assign apb_wr    = psel_i && penable_i && pwrite_i && mapped(paddr_i);
  assign init_busy = (r.state != wrap_pos_pkg::ST_RUN);
  assign busy_op   = init_busy || homing_i;
  assign prdata_o  = r.prdata;

  // valid once a coordinate is set; dropped while homing or initialising
  assign coordinate_valid_flag_o = r.coord_set && !homing_i && !init_busy;
  assign factory_home_flag_o     = factory_home_i;
  assign user_home_flag_o        = r.user_home;
  assign hs_home_ok_o = hs_home_req_i && coordinate_valid_flag_o;
  assign abs_pos_ok_o = abs_pos_req_i && (coordinate_valid_flag_o || r.permit);
  assign command_step_counter_o  = r.cmd_cnt;
  assign feedback_step_counter_o = r.fb_cnt;
  assign wrap_pos_o              = r.wrap_pos;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic [45:0] shift_prod;
  logic [31:0] shift_steps;
  logic [32:0] trial;
  logic [31:0] mod_val;
  logic [31:0] wrap_top;
  logic        do_preset;
  logic        do_clear;

  always_comb begin
    next_r      = r;
    next_r.nvm_we = 1'b0;
    shift_prod  = 46'(r.act_len) * 46'(r.ratio);
    shift_steps = 32'(shift_prod / 46'(`WP_RATIO_FULL));
    trial       = {r.rem[31:0], r.dvd[31]};
    mod_val     = (r.neg && (r.rem != 33'h0)) ? (r.act_len - r.rem[31:0]) : r.rem[31:0];
    wrap_top    = r.act_min + r.act_len - 32'h0000_0001;
    do_preset   = 1'b0;
    do_clear    = 1'b0;

    // ---- register writes ----
    if (apb_wr) begin
      unique case (paddr_i)
        `WP_OFF_CTRL: begin
          next_r.manual = pwdata_i[`WP_CTRL_MANUAL];
          next_r.permit = pwdata_i[`WP_CTRL_PERMIT];
          // wrap settings editable only in manual mode
          if (r.manual) begin
            next_r.wrap_en = pwdata_i[`WP_CTRL_WRAP_EN];
          end
        end
        `WP_OFF_RANGE: begin
          if (r.manual) begin
            next_r.range = pwdata_i;
          end
        end
        `WP_OFF_RATIO: begin
          if (r.manual) begin
            next_r.ratio = pwdata_i[13:0];
          end
        end
        `WP_OFF_OFSVAL: begin
          if (r.manual) begin
            next_r.ofsval = pwdata_i;
          end
        end
        `WP_OFF_HOME_OFS: next_r.home_ofs = pwdata_i;
        `WP_OFF_CMD: begin
          do_preset = pwdata_i[`WP_CMD_PRESET];
          do_clear  = pwdata_i[`WP_CMD_CLEAR];
          // settings take hold when init reruns: reinit, preset or homing completion
          if (pwdata_i[`WP_CMD_REINIT]) begin
            next_r.state = wrap_pos_pkg::ST_INIT;
          end
          if (pwdata_i[`WP_CMD_RESOL] && r.preset_nz) begin
            next_r.coord_set = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // ---- read data captured in setup phase ----
    if (psel_i && !penable_i) begin
      unique case (paddr_i)
        `WP_OFF_CTRL:     next_r.prdata = {29'h0, r.permit, r.manual, r.wrap_en};
        `WP_OFF_RANGE:    next_r.prdata = r.range;
        `WP_OFF_RATIO:    next_r.prdata = {18'h0, r.ratio};
        `WP_OFF_OFSVAL:   next_r.prdata = r.ofsval;
        `WP_OFF_HOME_OFS: next_r.prdata = r.home_ofs;
        `WP_OFF_STATUS: begin
          next_r.prdata = {26'h0, r.preset_nz, nvm_worn, init_busy,
                           r.user_home, factory_home_i, coordinate_valid_flag_o};
        end
        `WP_OFF_FB_CNT:     next_r.prdata = r.fb_cnt;
        `WP_OFF_CMD_CNT:    next_r.prdata = r.cmd_cnt;
        `WP_OFF_WRAP_POS:   next_r.prdata = r.wrap_pos;
        `WP_OFF_REVS:       next_r.prdata = {16'h0, r.revs};
        `WP_OFF_NVM_WRITES: next_r.prdata = {15'h0, nvm_writes};
        default:            next_r.prdata = 32'h0000_0000;
      endcase
    end

    // ---- motion counting, never stopped ----
    // command counter one per step; natural rollover
    if (cmd_step_i) begin
      next_r.cmd_cnt = cmd_dir_i ? r.cmd_cnt + 32'h0000_0001 : r.cmd_cnt - 32'h0000_0001;
    end
    if (fb_step_i) begin
      // wrap never touches the step counter; counts regardless
      next_r.fb_cnt = fb_dir_i ? r.fb_cnt + 32'h0000_0001 : r.fb_cnt - 32'h0000_0001;
      if (fb_dir_i) begin
        if (r.sub_step == SPR_LAST) begin
          next_r.sub_step = 32'h0000_0000;
          next_r.revs     = (r.revs == SPAN) ? 16'h0000 : r.revs + 16'h0001;
        end else begin
          next_r.sub_step = r.sub_step + 32'h0000_0001;
        end
      end else begin
        if (r.sub_step == 32'h0000_0000) begin
          next_r.sub_step = SPR_LAST;
          next_r.revs     = (r.revs == 16'h0000) ? SPAN : r.revs - 16'h0001;
        end else begin
          next_r.sub_step = r.sub_step - 32'h0000_0001;
        end
      end
      if (!r.act_wrap) begin
        next_r.wrap_pos = next_r.fb_cnt;
      end else if (fb_dir_i) begin
        // wrap presets at upper edge; jumps to opposite end
        next_r.wrap_pos = (r.wrap_pos == wrap_top) ? r.act_min : r.wrap_pos + 32'h0000_0001;
      end else begin
        // wrap presets at lower edge; jumps to opposite end
        next_r.wrap_pos = (r.wrap_pos == r.act_min) ? wrap_top : r.wrap_pos - 32'h0000_0001;
      end
    end

    // ---- coordinate generation sequence ----
    unique case (r.state)
      wrap_pos_pkg::ST_INIT: begin
        next_r.act_len  = r.range;
        next_r.act_wrap = r.wrap_en && (r.range != 32'h0000_0000);
        next_r.coord_set = factory_home_i || nvm_rdata[32] || r.coord_set;
        next_r.user_home = !factory_home_i && (nvm_rdata[32] || r.user_home);
        if (r.wrap_en && (r.range != 32'h0000_0000)) begin
          next_r.state = wrap_pos_pkg::ST_DIV;
        end else begin
          next_r.wrap_pos = r.fb_cnt;
          next_r.state    = wrap_pos_pkg::ST_RUN;
        end
      end
      wrap_pos_pkg::ST_DIV: begin
        // lower bound is offset value minus ratio share
        if (r.div_cnt == 6'h00) begin
          next_r.act_min = r.ofsval - shift_steps;
          next_r.neg     = $signed(r.fb_cnt - (r.ofsval - shift_steps)) < 0;
          next_r.dvd     = ($signed(r.fb_cnt - (r.ofsval - shift_steps)) < 0)
                         ? (r.ofsval - shift_steps) - r.fb_cnt
                         : r.fb_cnt - (r.ofsval - shift_steps);
          next_r.rem     = 33'h0_0000_0000;
          next_r.div_cnt = 6'h01;
        end else if (r.div_cnt <= `WP_DIV_STEPS) begin
          next_r.rem     = (trial >= {1'b0, r.act_len}) ? trial - {1'b0, r.act_len} : trial;
          next_r.dvd     = {r.dvd[30:0], 1'b0};
          next_r.div_cnt = r.div_cnt + 6'h01;
        end else begin
          // presented position is remainder plus lower bound
          next_r.wrap_pos = mod_val + r.act_min;
          next_r.div_cnt  = 6'h00;
          next_r.state    = wrap_pos_pkg::ST_RUN;
        end
      end
      wrap_pos_pkg::ST_RUN: ;
    endcase

    // ---- preset, homing completion, clear ----
    // factory home cannot be replaced or released
    if ((do_preset || homing_done_i) && !factory_home_i && !init_busy) begin
      // both counters take the home offset
      next_r.cmd_cnt   = r.home_ofs;
      next_r.fb_cnt    = r.home_ofs;
      next_r.sub_step  = 32'h0000_0000;
      next_r.revs      = 16'h0000;
      // user home flag set; coordinates centred on home
      next_r.user_home = 1'b1;
      next_r.coord_set = 1'b1;
      next_r.preset_nz = (r.home_ofs != 32'h0000_0000);
      next_r.nvm_we    = 1'b1;
      next_r.nvm_wdata = {1'b1, r.home_ofs};
      next_r.state     = wrap_pos_pkg::ST_INIT;
    end else if (do_clear && !factory_home_i && !busy_op) begin
      next_r.user_home = 1'b0;
      next_r.coord_set = 1'b0;
      next_r.preset_nz = 1'b0;
      next_r.nvm_we    = r.user_home;
      next_r.nvm_wdata = 33'h0_0000_0000;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      r           <= '0;
      r.state     <= wrap_pos_pkg::ST_INIT;
      r.range     <= `WP_RST_RANGE;
      r.ratio     <= `WP_RST_RATIO;
      r.ofsval    <= `WP_RST_OFSVAL;
      r.home_ofs  <= `WP_RST_HOME_OFS;
    end else begin
      r <= next_r;
    end
  end

endmodule : wrap_position_coordinate_manager

// ==== sim/wrap_pos_checker.sv ====
// port assertions of the wrap position coordinate manager
`timescale 1ns/100ps
`include "wrap_pos_defs.svh"
module wrap_pos_checker (
  input wire logic        clk_i,                   // clock
  input wire logic        reset_n_i,               // reset, active low
  input wire logic        psel_i,                  // apb select
  input wire logic        penable_i,               // apb enable
  input wire logic        pwrite_i,                // apb direction
  input wire logic [7:0]  paddr_i,                 // apb address
  input wire logic [31:0] pwdata_i,                // apb write data
  input wire logic        pready_o,                // apb ready
  input wire logic        pslverr_o,               // apb error
  input wire logic        cmd_step_i,              // command step
  input wire logic        fb_step_i,               // feedback step
  input wire logic        fb_dir_i,                // feedback direction
  input wire logic        homing_i,                // homing running
  input wire logic        homing_done_i,           // homing end
  input wire logic        factory_home_i,          // sensor factory home
  input wire logic        abs_pos_req_i,           // absolute request
  input wire logic        hs_home_req_i,           // fast homing request
  input wire logic        abs_pos_ok_o,            // absolute grant
  input wire logic        hs_home_ok_o,            // fast homing grant
  input wire logic        coordinate_valid_flag_o, // coordinate set
  input wire logic        factory_home_flag_o,     // factory home flag
  input wire logic        user_home_flag_o,        // user home flag
  input wire logic [31:0] command_step_counter_o,  // command count
  input wire logic [31:0] feedback_step_counter_o  // feedback count
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  logic [1:0] up;
  logic       live;
  logic       cmd_wr;
  // counters follow steps only once the synchronised reset has let go
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) up <= 2'h0;
    else if (up != 2'h3) up <= up + 2'h1;
  end
  assign live   = (up == 2'h3);
  assign cmd_wr = psel_i && penable_i && pwrite_i && (paddr_i == `WP_OFF_CMD);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  chk_pready_high: assert property (pready_o)
    else $error("ready low");
  chk_slverr_map: assert property (pslverr_o == (psel_i && penable_i &&
    (paddr_i > `WP_OFF_NVM_WRITES || paddr_i[1:0] != 2'h0))) else $error("error flag wrong");
  chk_fb_count_up: assert property (live && fb_step_i && fb_dir_i && !homing_done_i && !cmd_wr
    |=> feedback_step_counter_o == $past(feedback_step_counter_o) + 32'h1) else $error("fb up");
  chk_fb_count_dn: assert property (live && fb_step_i && !fb_dir_i && !homing_done_i && !cmd_wr
    |=> feedback_step_counter_o == $past(feedback_step_counter_o) - 32'h1) else $error("fb down");
  chk_cmd_count_hold: assert property (live && !cmd_step_i && !homing_done_i && !cmd_wr
    |=> $stable(command_step_counter_o)) else $error("command count moved");
  chk_valid_homing: assert property (homing_i |-> !coordinate_valid_flag_o)
    else $error("valid during homing");
  chk_factory_flag: assert property (factory_home_flag_o == factory_home_i)
    else $error("factory flag wrong");
  chk_hs_gate: assert property (hs_home_ok_o |-> hs_home_req_i && coordinate_valid_flag_o)
    else $error("fast homing granted");
  chk_abs_gate: assert property (abs_pos_ok_o |-> abs_pos_req_i)
    else $error("absolute granted");
  chk_user_rise: assert property ($rose(user_home_flag_o)
    |-> $past(homing_done_i) || $past(cmd_wr && pwdata_i[0])) else $error("user flag rose");
endmodule : wrap_pos_checker

bind wrap_position_coordinate_manager wrap_pos_checker i_chk (.*);

// ==== sim/abs_sensor_model.sv ====
// behavioural model of the multi-turn absolute position sensor
`timescale 1ns/100ps
module abs_sensor_model #(
  parameter int STEPS_PER_REV = 4,
  parameter int SPAN_REVS     = 1800
) (
  input  wire logic clk_i,          // clock
  input  wire logic factory_set_i,  // factory home stored
  output logic      fb_step_o,      // step pulse
  output logic      fb_dir_o,       // direction, 1 positive
  output logic      factory_home_o  // factory home to the block
);
  int sub  = 0;
  int revs = 0;
  initial begin
    fb_step_o = 1'b0;
    fb_dir_o  = 1'b0;
  end
  assign factory_home_o = factory_set_i;
  // one pulse per step; direction is released to its inverse afterwards
  task automatic step1(input logic d);
    @(posedge clk_i);
    fb_dir_o  <= d;
    fb_step_o <= 1'b1;
    @(posedge clk_i);
    fb_step_o <= 1'b0;
    fb_dir_o  <= ~d;
    sub = d ? sub + 1 : sub - 1;
    // revolution count restarts past the span
    if (sub == STEPS_PER_REV || sub == -STEPS_PER_REV) begin
      sub  = 0;
      revs = (revs >= SPAN_REVS) ? 0 : revs + 1;
    end
  endtask : step1
endmodule : abs_sensor_model

// ==== sim/tb_wrap_position_coordinate_manager.sv ====
// self-checking bench of the wrap position coordinate manager
`timescale 1ns/100ps
`include "wrap_pos_defs.svh"
module tb_wrap_position_coordinate_manager;
  typedef struct {
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] r;
    logic [31:0] e;
  } row_s;
  logic        clk_i         = 1'b0;
  logic        reset_n_i     = 1'b0;
  logic        psel_i        = 1'b0;
  logic        penable_i     = 1'b0;
  logic        pwrite_i      = 1'b0;
  logic [7:0]  paddr_i       = 8'h00;
  logic [31:0] pwdata_i      = 32'h0;
  logic        cmd_step_i    = 1'b0;
  logic        cmd_dir_i     = 1'b0;
  logic        homing_i      = 1'b0;
  logic        homing_done_i = 1'b0;
  logic        abs_pos_req_i = 1'b0;
  logic        hs_home_req_i = 1'b0;
  logic        factory_set   = 1'b0;
  logic        fb_step_i, fb_dir_i, factory_home_i, pready_o, pslverr_o;
  logic        abs_pos_ok_o, hs_home_ok_o, user_home_flag_o;
  logic        coordinate_valid_flag_o, factory_home_flag_o;
  logic [31:0] prdata_o, command_step_counter_o, feedback_step_counter_o, wrap_pos_o, r, e;
  int          n_fail = 0, samples_checked = 0, fbx = 0;
  row_s        rows [9] = '{
    '{`WP_OFF_RANGE, 32'h5, 32'h0, 32'h0},
    '{`WP_OFF_CTRL, 32'h2, 32'h2, 32'h0},
    '{`WP_OFF_RANGE, 32'h28, 32'h28, 32'h0},
    '{`WP_OFF_RATIO, 32'h1388, 32'h1388, 32'h0},
    '{`WP_OFF_OFSVAL, 32'h0, 32'h0, 32'h0},
    '{`WP_OFF_HOME_OFS, 32'h8000_0000, 32'h8000_0000, 32'h0},
    '{`WP_OFF_HOME_OFS, 32'h7FFF_FFFF, 32'h7FFF_FFFF, 32'h0},
    '{8'h30, 32'h1, 32'h0, 32'h1},
    '{8'h06, 32'h1, 32'h0, 32'h1}
  };

  wrap_position_coordinate_manager #(
    .STEPS_PER_REV (4),
    .NVM_LIMIT     (4)
  ) i_dut (.*);
  abs_sensor_model i_sensor (
    .clk_i          (clk_i),
    .factory_set_i  (factory_set),
    .fb_step_o      (fb_step_i),
    .fb_dir_o       (fb_dir_i),
    .factory_home_o (factory_home_i)
  );

  always #25 clk_i = ~clk_i;

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    r = prdata_o;
    e = 32'(pslverr_o);
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic cstep(input logic d);
    @(posedge clk_i);
    cmd_step_i <= 1'b1;
    cmd_dir_i  <= d;
    @(posedge clk_i);
    cmd_step_i <= 1'b0;
    @(negedge clk_i);
  endtask : cstep

  task automatic wait_valid();
    for (int k = 0; k < 100 && coordinate_valid_flag_o !== 1'b1; k++) @(negedge clk_i);
  endtask : wait_valid

  // range 40 steps, half of it below zero
  function automatic int exp_wrap(input int f);
    int m;
    m = -(40 * 5000 / 10000);
    return (((f - m) % 40) + 40) % 40 + m;
  endfunction : exp_wrap

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    #(50 * 10000);
    n_fail++;
    final_report();
  end

  initial begin
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    check(32'(coordinate_valid_flag_o), 32'h0);
    for (int i = 0; i < 12; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      check(r, 32'h0);
    end
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      check(e, rows[i].e);
      apb(1'b0, rows[i].a, 32'h0);
      check(r, rows[i].r);
      check(e, rows[i].e);
    end
    apb(1'b1, `WP_OFF_CTRL, 32'h3);
    apb(1'b1, `WP_OFF_CMD, 32'h4);
    repeat (40) @(posedge clk_i);
    // 45 steps up then 90 down cross both ends of the 40-step range
    for (int i = 0; i < 135; i++) begin
      fbx += (i < 45) ? 1 : -1;
      i_sensor.step1(i < 45);
      @(negedge clk_i);
      check(feedback_step_counter_o, 32'(fbx));
      check(wrap_pos_o, 32'(exp_wrap(fbx)));
    end
    apb(1'b0, `WP_OFF_REVS, 32'h0);
    check(r, 32'h0000_06FD);
    apb(1'b1, `WP_OFF_HOME_OFS, 32'h8000_0000);
    apb(1'b1, `WP_OFF_CMD, 32'h1);
    @(negedge clk_i);
    check(command_step_counter_o, 32'h8000_0000);
    check(feedback_step_counter_o, 32'h8000_0000);
    check(32'(user_home_flag_o), 32'h1);
    wait_valid();
    check(32'(coordinate_valid_flag_o), 32'h1);
    cstep(1'b0);
    check(command_step_counter_o, 32'h7FFF_FFFF);
    cstep(1'b1);
    check(command_step_counter_o, 32'h8000_0000);
    i_sensor.step1(1'b0);
    @(negedge clk_i);
    check(feedback_step_counter_o, 32'h7FFF_FFFF);
    @(posedge clk_i);
    hs_home_req_i <= 1'b1;
    abs_pos_req_i <= 1'b1;
    homing_i      <= 1'b1;
    @(negedge clk_i);
    check(32'(coordinate_valid_flag_o), 32'h0);
    @(posedge clk_i);
    homing_done_i <= 1'b1;
    @(posedge clk_i);
    homing_done_i <= 1'b0;
    homing_i      <= 1'b0;
    @(negedge clk_i);
    check(feedback_step_counter_o, 32'h8000_0000);
    wait_valid();
    check(32'(hs_home_ok_o), 32'h1);
    apb(1'b0, `WP_OFF_NVM_WRITES, 32'h0);
    check(r, 32'h2);
    apb(1'b1, `WP_OFF_CMD, 32'h8);
    @(negedge clk_i);
    check(32'(coordinate_valid_flag_o), 32'h0);
    check(32'(hs_home_ok_o), 32'h0);
    check(32'(abs_pos_ok_o), 32'h0);
    apb(1'b1, `WP_OFF_CTRL, 32'h7);
    @(negedge clk_i);
    check(32'(abs_pos_ok_o), 32'h1);
    apb(1'b1, `WP_OFF_CMD, 32'h2);
    @(negedge clk_i);
    check(32'(user_home_flag_o), 32'h0);
    apb(1'b0, `WP_OFF_NVM_WRITES, 32'h0);
    check(r, 32'h0000_0003);
    apb(1'b1, `WP_OFF_HOME_OFS, 32'h5);
    factory_set <= 1'b1;
    apb(1'b1, `WP_OFF_CMD, 32'h1);
    @(negedge clk_i);
    check(32'(factory_home_flag_o), 32'h1);
    check(32'(user_home_flag_o), 32'h0);
    check(feedback_step_counter_o, 32'h8000_0000);
    final_report();
  end
endmodule : tb_wrap_position_coordinate_manager
